// >>> core/cxs_host.sv
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`default_nettype none
module cxs_host (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   cxs_if.host bus
);
   typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} cxs_hst_t;

   cxs_hst_t state_ff;
   logic aw_got_ff;
   logic w_got_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [2:0] ctrl_ff;
   logic [2:0] addr_ff;
   logic [15:0] txd_ff;
   logic [15:0] rxd_ff;
   logic done_ff;
   logic nack_ff;
   logic [cxs_pkg::DIV_W-1:0] div_ff;
   logic [1:0] qc_ff;
   logic [3:0] bit_ff;
   logic [1:0] byte_ff;
   logic [23:0] frame_ff;
   logic rd_ff;
   logic scl_oe_ff;
   logic sda_oe_ff;
   logic wr_go;
   logic [31:0] wr_val;
   logic go_c;
   logic tick;
   logic sending;
   logic nxt_scl_oe;
   logic nxt_sda_oe;

   // ************************************************
   // register bus
   // ************************************************
   assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
   assign s_axi_arready = ~rvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign wr_go = aw_got_ff & w_got_ff;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wr_val[i*8 +: 8] = wdata_ff[i*8 +: 8];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'h0;
         w_got_ff <= 1'h0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'h0;
         bresp_ff <= cxs_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'h1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'h1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got_ff <= 1'h0;
            w_got_ff <= 1'h0;
            bvalid_ff <= 1'h1;
            case ({awaddr_ff[7:2], 2'h0})
               cxs_pkg::REG_CTRL, cxs_pkg::REG_ADDR, cxs_pkg::REG_TXD,
               cxs_pkg::REG_STAT, cxs_pkg::REG_RXD:
                  bresp_ff <= cxs_pkg::RESP_OKAY;
               default: bresp_ff <= cxs_pkg::RESP_SLVERR;
            endcase
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'h0;
         end
      end
   end

   // control writes; go is refused while busy or when the same write sets hold
   assign go_c = wr_go && {awaddr_ff[7:2], 2'h0} == cxs_pkg::REG_CTRL &&
                 wstrb_ff[0] && wr_val[cxs_pkg::CTRL_GO] &&
                 !wr_val[cxs_pkg::CTRL_HOLD] && state_ff == H_IDLE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= cxs_pkg::CTRL_RST;
         addr_ff <= cxs_pkg::ADDR_RST;
         txd_ff <= cxs_pkg::TXD_RST;
      end else if (wr_go) begin
         case ({awaddr_ff[7:2], 2'h0})
            cxs_pkg::REG_CTRL: begin
               if (wstrb_ff[0]) begin
                  ctrl_ff <= {wr_val[2:1], 1'h0};
               end
            end
            cxs_pkg::REG_ADDR: begin
               if (wstrb_ff[0]) begin
                  addr_ff <= wr_val[2:0];
               end
            end
            cxs_pkg::REG_TXD: begin
               if (wstrb_ff[0]) begin
                  txd_ff[7:0] <= wr_val[7:0];
               end
               if (wstrb_ff[1]) begin
                  txd_ff[15:8] <= wr_val[15:8];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'h0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= cxs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'h1;
         rresp_ff <= cxs_pkg::RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'h0})
            cxs_pkg::REG_CTRL: rdata_ff <= {29'h0, ctrl_ff};
            cxs_pkg::REG_ADDR: rdata_ff <= {29'h0, addr_ff};
            cxs_pkg::REG_TXD: rdata_ff <= {16'h0000, txd_ff};
            cxs_pkg::REG_STAT: rdata_ff <= {29'h0, nack_ff, done_ff,
                                            state_ff != H_IDLE};
            cxs_pkg::REG_RXD: rdata_ff <= {16'h0000, rxd_ff};
            default: begin
               rdata_ff <= 32'h00000000;
               rresp_ff <= cxs_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'h0;
      end
   end

   // ************************************************
   // serial frame engine
   // ************************************************
   assign tick = state_ff != H_IDLE &&
                 div_ff == cxs_pkg::DIV_W'(cxs_pkg::QTR_CYC - 1);
   assign sending = byte_ff == 2'h0 || !rd_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= H_IDLE;
         div_ff <= '0;
         qc_ff <= 2'h0;
         bit_ff <= 4'h0;
         byte_ff <= 2'h0;
         frame_ff <= 24'h000000;
         rd_ff <= 1'h0;
         rxd_ff <= 16'h0000;
         done_ff <= 1'h0;
         nack_ff <= 1'h0;
      end else if (go_c) begin
         state_ff <= H_START;
         div_ff <= '0;
         qc_ff <= 2'h0;
         bit_ff <= 4'h0;
         byte_ff <= 2'h0;
         rd_ff <= wr_val[cxs_pkg::CTRL_RD];
         // address byte and direction open every frame
         frame_ff <= {cxs_pkg::DEV_ADDR_HI, addr_ff,
                      wr_val[cxs_pkg::CTRL_RD], txd_ff};
         rxd_ff <= 16'h0000;
         done_ff <= 1'h0;
         nack_ff <= 1'h0;
      end else if (state_ff != H_IDLE) begin
         div_ff <= tick ? '0 : div_ff + 1'h1;
         if (tick) begin
            qc_ff <= qc_ff + 2'h1;
            case (state_ff)
               H_START: begin
                  if (qc_ff == 2'h3) begin
                     state_ff <= H_BITS;
                  end
               end
               H_BITS: begin
                  if (qc_ff == 2'h2) begin
                     if (bit_ff == 4'h8 && sending && bus.sda) begin
                        nack_ff <= 1'h1;
                     end
                     if (bit_ff != 4'h8 && !sending) begin
                        rxd_ff <= {rxd_ff[14:0], bus.sda};
                     end
                  end else if (qc_ff == 2'h3) begin
                     if (bit_ff == 4'h8) begin
                        bit_ff <= 4'h0;
                        byte_ff <= byte_ff + 2'h1;
                        if (byte_ff == 2'h2 || nack_ff) begin
                           state_ff <= H_STOP;
                        end
                     end else begin
                        bit_ff <= bit_ff + 4'h1;
                        frame_ff <= {frame_ff[22:0], 1'h1};
                     end
                  end
               end
               H_STOP: begin
                  if (qc_ff == 2'h3) begin
                     state_ff <= H_IDLE;
                     done_ff <= 1'h1;
                  end
               end
               default: begin
                  state_ff <= H_IDLE;
               end
            endcase
         end
      end
   end

   // ************************************************
   // pin drive
   // ************************************************
   always_comb begin
      nxt_scl_oe = 1'h0;
      nxt_sda_oe = 1'h0;
      case (state_ff)
         H_START: nxt_sda_oe = qc_ff[1];
         H_BITS: begin
            nxt_scl_oe = ~qc_ff[1];
            if (bit_ff != 4'h8) begin
               nxt_sda_oe = sending & ~frame_ff[23];
            end else begin
               // ack the first read byte, let the last one go
               nxt_sda_oe = ~sending & byte_ff == 2'h1;
            end
         end
         H_STOP: begin
            nxt_scl_oe = qc_ff == 2'h0;
            nxt_sda_oe = ~qc_ff[1];
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_oe_ff <= 1'h0;
         sda_oe_ff <= 1'h0;
      end else begin
         scl_oe_ff <= nxt_scl_oe;
         sda_oe_ff <= nxt_sda_oe;
      end
   end

   assign bus.scl_o = 1'h0;
   assign bus.scl_oe = scl_oe_ff;
   assign bus.m_sda_o = 1'h0;
   assign bus.m_sda_oe = sda_oe_ff;
   // hold only reaches the pin between frames, never in mid-write
   assign bus.array_rst_n = ~(ctrl_ff[cxs_pkg::CTRL_HOLD] &&
                              state_ff == H_IDLE);
endmodule
`default_nettype wire

// >>> core/cxs_pkg.sv
// ************************************************
// ************************************************
`default_nettype none
package cxs_pkg;
   // clock and serial timing
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCL_QTR_NS = 2500;
   localparam int QTR_CYC = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_W = 8;
   // slave address and array shape
   localparam logic [3:0] DEV_ADDR_HI = 4'hE;
   localparam int NUM_X = 10;
   localparam int NUM_Y = 8;
   // command fields, hi byte then lo byte
   localparam int CMD_DATA_BIT = 7;
   localparam int CMD_X_MSB = 6;
   localparam int CMD_X_LSB = 3;
   localparam int CMD_Y_MSB = 2;
   localparam int CMD_Y_LSB = 0;
   localparam int CMD_APPLY_BIT = 0;
   localparam logic [3:0] X_CODE [NUM_X] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h8,
                                            4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
   localparam logic [7:0] RB_CODE [NUM_X] = '{8'h74, 8'h7C, 8'h35, 8'h3D,
                                             8'h75, 8'h7D, 8'h36, 8'h3E,
                                             8'h76, 8'h7E};
   localparam logic [7:0] RB_LEAD = 8'h00;
   // controller registers
   localparam int AXI_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_TXD = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   localparam logic [7:0] REG_RXD = 8'h10;
   localparam int CTRL_GO = 0;
   localparam int CTRL_RD = 1;
   localparam int CTRL_HOLD = 2;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_NACK = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [2:0] ADDR_RST = 3'h0;
   localparam logic [15:0] TXD_RST = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> core/cxs_if.sv
`default_nettype none
interface cxs_if;
   logic scl_o;
   logic scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic array_rst_n;
   logic scl;
   logic sda;
   // open-drain wires: low while any enabled driver drives low
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
   modport host (output scl_o, scl_oe, m_sda_o, m_sda_oe, array_rst_n,
                 input sda);
   modport dev (output s_sda_o, s_sda_oe,
                input scl, sda, array_rst_n);
endinterface
`default_nettype wire

// >>> core/cxs_dev.sv
`default_nettype none
module cxs_dev (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [2:0] addr_select_pins,
   output logic [79:0] switch_state,
   output logic [79:0] latched_state,
   cxs_if.dev bus
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_AACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
   } cxs_dst_t;

   cxs_dst_t state_ff;
   logic scl_q_ff;
   logic sda_q_ff;
   logic [2:0] bit_ff;
   logic done_ff;
   logic [7:0] shift_ff;
   logic nack_ff;
   logic wbyte_ff;
   logic [7:0] hi_ff;
   logic [7:0] tx_ff;
   logic rbyte_ff;
   logic [7:0] hold_ff;
   logic sda_oe_ff;
   logic [7:0] latch_ff [cxs_pkg::NUM_X];
   logic [7:0] active_ff [cxs_pkg::NUM_X];
   logic [7:0] nxt_latch [cxs_pkg::NUM_X];
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic addr_hit;
   logic wr_byte_c;
   logic exec_c;
   logic sel_ok;
   logic [3:0] sel_x;
   logic rb_ok;
   logic [3:0] rb_x;
   logic nxt_sda_oe;

   // ************************************************
   // bus conditions
   // ************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_q_ff <= 1'h1;
         sda_q_ff <= 1'h1;
      end else begin
         scl_q_ff <= bus.scl;
         sda_q_ff <= bus.sda;
      end
   end

   assign scl_rise = bus.scl & ~scl_q_ff;
   assign scl_fall = ~bus.scl & scl_q_ff;
   assign start_c = bus.scl & scl_q_ff & sda_q_ff & ~bus.sda;
   assign stop_c = bus.scl & scl_q_ff & ~sda_q_ff & bus.sda;
   assign addr_hit = shift_ff[7:1] ==
                     {cxs_pkg::DEV_ADDR_HI, addr_select_pins};

   // ************************************************
   // byte engine
   // ************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_IDLE;
         bit_ff <= 3'h0;
         done_ff <= 1'h0;
         shift_ff <= 8'h00;
         nack_ff <= 1'h0;
      end else if (start_c) begin
         // a repeated start restarts the address phase
         state_ff <= ST_ADDR;
         bit_ff <= 3'h0;
         done_ff <= 1'h0;
      end else if (stop_c) begin
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_ADDR, ST_WDATA: begin
               if (scl_rise) begin
                  shift_ff <= {shift_ff[6:0], bus.sda};
                  bit_ff <= bit_ff + 3'h1;
                  if (bit_ff == 3'h7) begin
                     done_ff <= 1'h1;
                  end
               end else if (scl_fall && done_ff) begin
                  done_ff <= 1'h0;
                  if (state_ff == ST_WDATA) begin
                     state_ff <= ST_WACK;
                  end else if (addr_hit) begin
                     state_ff <= ST_AACK;
                  end else begin
                     state_ff <= ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  state_ff <= shift_ff[0] ? ST_RDATA : ST_WDATA;
               end
            end
            ST_WACK: begin
               if (scl_fall) begin
                  state_ff <= ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  bit_ff <= bit_ff + 3'h1;
                  if (bit_ff == 3'h7) begin
                     done_ff <= 1'h1;
                  end
               end else if (scl_fall && done_ff) begin
                  done_ff <= 1'h0;
                  state_ff <= ST_RACK;
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  nack_ff <= bus.sda;
               end else if (scl_fall) begin
                  state_ff <= nack_ff ? ST_IDLE : ST_RDATA;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************
   // command assembly
   // ************************************************
   assign wr_byte_c = (state_ff == ST_WDATA) & scl_fall & done_ff & ~stop_c &
                      ~start_c;
   assign exec_c = wr_byte_c & wbyte_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wbyte_ff <= 1'h0;
         hi_ff <= 8'h00;
      end else if (state_ff == ST_AACK) begin
         wbyte_ff <= 1'h0;
      end else if (wr_byte_c) begin
         // extra bytes pair up again as further commands
         wbyte_ff <= ~wbyte_ff;
         if (!wbyte_ff) begin
            hi_ff <= shift_ff;
         end
      end
   end

   always_comb begin
      sel_ok = 1'h0;
      sel_x = 4'h0;
      rb_ok = 1'h0;
      rb_x = 4'h0;
      for (int i = 0; i < cxs_pkg::NUM_X; i++) begin
         if (hi_ff[cxs_pkg::CMD_X_MSB:cxs_pkg::CMD_X_LSB] ==
             cxs_pkg::X_CODE[i]) begin
            sel_ok = 1'h1;
            sel_x = 4'(i);
         end
         if (hi_ff == cxs_pkg::RB_CODE[i]) begin
            rb_ok = 1'h1;
            rb_x = 4'(i);
         end
      end
   end

   // ************************************************
   // switch array
   // ************************************************
   always_comb begin
      for (int i = 0; i < cxs_pkg::NUM_X; i++) begin
         nxt_latch[i] = latch_ff[i];
      end
      if (sel_ok && !rb_ok) begin
         nxt_latch[sel_x][hi_ff[cxs_pkg::CMD_Y_MSB:cxs_pkg::CMD_Y_LSB]] =
            hi_ff[cxs_pkg::CMD_DATA_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      // the array reset pin wins over any command in flight
      if (!aresetn || !bus.array_rst_n) begin
         for (int i = 0; i < cxs_pkg::NUM_X; i++) begin
            latch_ff[i] <= 8'h00;
            active_ff[i] <= 8'h00;
         end
      end else if (exec_c && !rb_ok) begin
         for (int i = 0; i < cxs_pkg::NUM_X; i++) begin
            latch_ff[i] <= nxt_latch[i];
            if (shift_ff[cxs_pkg::CMD_APPLY_BIT]) begin
               active_ff[i] <= nxt_latch[i];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_ff <= 8'h00;
      end else if (exec_c && rb_ok) begin
         hold_ff <= active_ff[rb_x];
      end
   end

   always_comb begin
      for (int i = 0; i < cxs_pkg::NUM_X; i++) begin
         switch_state[i*8 +: 8] = active_ff[i];
         latched_state[i*8 +: 8] = latch_ff[i];
      end
   end

   // ************************************************
   // readback shifter
   // ************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_ff <= 8'h00;
         rbyte_ff <= 1'h0;
      end else if (state_ff == ST_AACK && scl_fall) begin
         tx_ff <= cxs_pkg::RB_LEAD;
         rbyte_ff <= 1'h1;
      end else if (state_ff == ST_RACK && scl_fall) begin
         // bit n of the holder is Y line n, sent msb first
         tx_ff <= rbyte_ff ? hold_ff : cxs_pkg::RB_LEAD;
         rbyte_ff <= ~rbyte_ff;
      end else if (state_ff == ST_RDATA && scl_fall && !done_ff) begin
         tx_ff <= {tx_ff[6:0], 1'h0};
      end
   end

   // ************************************************
   // data line drive
   // ************************************************
   always_comb begin
      case (state_ff)
         ST_AACK, ST_WACK: nxt_sda_oe = 1'h1;
         ST_RDATA: nxt_sda_oe = ~tx_ff[7];
         default: nxt_sda_oe = 1'h0;
      endcase
   end

   // one cycle of lag is far inside a quarter bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sda_oe_ff <= 1'h0;
      end else begin
         sda_oe_ff <= nxt_sda_oe;
      end
   end

   assign bus.s_sda_o = 1'h0;
   assign bus.s_sda_oe = sda_oe_ff;
endmodule
`default_nettype wire

// >>> verification/cxs_sva.sv
`default_nettype none
// *****
// checks on the shared serial wires
// *****
module cxs_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_oe,
   input wire logic m_sda_oe,
   input wire logic s_sda_oe,
   input wire logic array_rst_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] idle_ff;
   logic [9:0] nxt_idle;
   // a clock high this long can only be an idle bus
   assign nxt_idle = (idle_ff == 10'h3FF) ? idle_ff : idle_ff + 10'h001;
   always_ff @(posedge aclk) begin
      if (!aresetn || !scl) begin
         idle_ff <= 10'h000;
      end else begin
         idle_ff <= nxt_idle;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_dev_drive_low: assert property ($rose(s_sda_oe) |-> !scl)
      else $error("device took data line while clock high");
   a_dev_free_low: assert property ($fell(s_sda_oe) |-> !scl)
      else $error("device freed data line while clock high");
   a_dev_bit_width: assert property ($rose(s_sda_oe) |=> s_sda_oe [*8])
      else $error("device drive shorter than a bit");
   a_dev_idle_quiet: assert property (idle_ff > 10'h258 |-> !s_sda_oe)
      else $error("device drives an idle bus");
   a_scl_high_hold: assert property ($rose(scl) |=> scl [*8])
      else $error("clock high phase too short");
   a_scl_low_hold: assert property ($fell(scl) |=> !scl [*8])
      else $error("clock low phase too short");
   a_hold_no_frame: assert property (!array_rst_n |-> !scl_oe && !m_sda_oe)
      else $error("frame runs while array reset low");
   a_wire_release: assert property ($rose(aresetn) |-> scl && sda)
      else $error("wires not released after reset");
   cover property ($rose(s_sda_oe));
   cover property ($fell(sda) && scl);
   cover property ($fell(array_rst_n));
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`default_nettype none
// *****
// bench: host over register bus, device across the wires
// *****
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [1:0] br;
   logic [79:0] sw, lat;
   int fail_count = 0, compares = 0, cyc = 0;
   cxs_if bus();
   cxs_host u_cxs_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .bus(bus));
   cxs_dev u_cxs_dev (.aclk(aclk), .aresetn(aresetn), .addr_select_pins(3'h5),
      .switch_state(sw), .latched_state(lat), .bus(bus));
   cxs_sva u_cxs_sva (.aclk(aclk), .aresetn(aresetn), .scl(bus.scl),
      .sda(bus.sda), .scl_oe(bus.scl_oe), .m_sda_oe(bus.m_sda_oe),
      .s_sda_oe(bus.s_sda_oe), .array_rst_n(bus.array_rst_n));
   always #12.5 aclk = ~aclk;
   task automatic chk(input logic [79:0] g, input logic [79:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      // response stands at the edge where bvalid is seen high
      br = bresp;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      v = rdata;
      r = rresp;
   endtask
   // one whole frame, then poll until the sticky done flag shows
   task automatic frame(input logic [15:0] t, input logic [2:0] c);
      logic [1:0] r;
      wr(cxs_pkg::REG_TXD, {16'h0000, t});
      wr(cxs_pkg::REG_CTRL, {29'h0, c});
      d = 32'h0;
      while (!d[cxs_pkg::STAT_DONE]) rd(cxs_pkg::REG_STAT, d, r);
   endtask
   task automatic test_done;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // five data frames take about 60000 cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 90000) begin
         fail_count++;
         test_done;
      end
   end
   initial begin
      logic [1:0] r;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(8'h20, d, r);
      chk({78'h0, r}, {78'h0, cxs_pkg::RESP_SLVERR});
      wr(8'h20, 32'h0);
      chk({78'h0, br}, {78'h0, cxs_pkg::RESP_SLVERR});
      wr(cxs_pkg::REG_ADDR, 32'h5);
      chk({78'h0, br}, {78'h0, cxs_pkg::RESP_OKAY});
      $display("test register bus done");
      frame(16'hAD00, 3'h1); // X3 to Y5 closed, not applied
      chk({79'h0, d[cxs_pkg::STAT_NACK]}, 80'h0);
      chk(lat, 80'h1 << 29);
      chk(sw, 80'h0);
      frame(16'hE801, 3'h1); // X9 to Y0 closed, apply all
      chk(sw, (80'h1 << 29) | (80'h1 << 72));
      frame(16'h2D01, 3'h1); // X3 to Y5 open
      chk(sw, 80'h1 << 72);
      $display("test switch writes done");
      frame(16'h7E00, 3'h1);
      frame(16'h0000, 3'h3);
      rd(cxs_pkg::REG_RXD, d, r);
      chk({64'h0, d[15:0]}, 80'h1);
      $display("test readback done");
      wr(cxs_pkg::REG_ADDR, 32'h2);
      // X3 to Y0 closed with apply: would show if the frame were taken
      frame(16'hA801, 3'h1);
      chk({79'h0, d[cxs_pkg::STAT_NACK]}, 80'h1);
      chk(sw, 80'h1 << 72);
      chk(lat, 80'h1 << 72);
      $display("test foreign address done");
      wr(cxs_pkg::REG_CTRL, 32'h4);
      repeat (2) @(posedge aclk);
      chk(sw | lat, 80'h0);
      wr(cxs_pkg::REG_CTRL, 32'h5);
      repeat (4) @(posedge aclk);
      rd(cxs_pkg::REG_STAT, d, r);
      chk({79'h0, d[cxs_pkg::STAT_BUSY]}, 80'h0);
      $display("test array reset done");
      test_done;
   end
endmodule
`default_nettype wire
